// ### src/smrf_pkg.sv
// Package for the SDRAM mode-register file: addresses, fields, timing
`default_nettype none
package smrf_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_DEVICE_INFO     = 8'h00;
  localparam logic [7:0] ADDR_BURST_FEATURE   = 8'h01;
  localparam logic [7:0] ADDR_LATENCY         = 8'h02;
  localparam logic [7:0] ADDR_IO_DRIVE        = 8'h03;
  localparam logic [7:0] ADDR_REFRESH_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MAKER_ID        = 8'h05;
  localparam logic [7:0] ADDR_REVISION_ONE    = 8'h06;
  localparam logic [7:0] ADDR_REVISION_TWO    = 8'h07;
  localparam logic [7:0] ADDR_GEOMETRY        = 8'h08;
  localparam logic [7:0] ADDR_TEST_MODE       = 8'h09;
  localparam logic [7:0] ADDR_IO_CALIB        = 8'h0a;
  localparam logic [7:0] ADDR_SR_BANK_MASK    = 8'h10;
  localparam logic [7:0] ADDR_SR_SEGMENT_MASK = 8'h11;
  localparam logic [7:0] ADDR_DQ_PATTERN_A    = 8'h20;
  localparam logic [7:0] ADDR_DQ_PATTERN_B    = 8'h28;
  localparam logic [7:0] ADDR_SOFT_RESET      = 8'h3f;

  // ==========================================================
  // Implemented-bit masks for readable registers and for the latency and I/O drive writes
  localparam logic [7:0] MASK_DEVICE_INFO     = 8'h1f;
  localparam logic [7:0] MASK_REFRESH_STATUS  = 8'h87;
  localparam logic [7:0] MASK_LATENCY         = 8'h0f;
  localparam logic [7:0] MASK_IO_DRIVE        = 8'h0f;
  localparam logic [7:0] MASK_FULL            = 8'hff;

  // ==========================================================
  // Reset / default values (writable config per documented defaults)
  localparam logic [7:0] RST_BURST_FEATURE    = 8'h22;
  localparam logic [7:0] RST_ZERO             = 8'h00;
  localparam logic [7:0] UNDEF_READ_DATA      = 8'h00;
  // Identity and geometry values: arbitrary neutral values
  localparam logic [7:0] ID_MAKER             = 8'h5a;
  localparam logic [7:0] ID_REVISION_ONE      = 8'h01;
  localparam logic [7:0] ID_REVISION_TWO      = 8'h00;
  localparam logic [7:0] GEOMETRY_VALUE       = 8'h10;
  localparam logic [7:0] DQ_PATTERN_A_VALUE   = 8'h00;
  localparam logic [7:0] DQ_PATTERN_B_VALUE   = 8'h00;
  localparam logic [2:0] REFRESH_RATE_NOMINAL = 3'h3;

  // ==========================================================
  // Field positions
  localparam int AUTO_INIT_BIT  = 0;
  localparam int TEMP_FLAG_BIT  = 7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS        = 8000;
  localparam int AUTO_INIT_MAX_US     = 10;
  localparam int AUTO_INIT_MAX_CYC    = (AUTO_INIT_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int POST_RESET_IDLE_US   = 1;
  localparam int POST_RESET_IDLE_CYC  =
    (POST_RESET_IDLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BURST_BEATS          = 4;

  // ==========================================================
  // Command carrier
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } smrf_cmd_s;

  typedef struct packed {
    logic       valid;
    logic       strobe;
    logic [7:0] data;
  } smrf_rsp_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } smrf_state_e;
endpackage
`default_nettype wire

// ### src/smrf_top.sv
// Mode-register file of a low-power SDRAM, command-driven
`default_nettype none
module smrf_top
  import smrf_pkg::*;
#(
  parameter int AUTO_INIT_CYC = AUTO_INIT_MAX_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire smrf_cmd_s  i_cmd,
  input  wire logic       i_temp_update,
  output var smrf_rsp_s   o_rsp,
  output logic [7:0]      o_burst_feature,
  output logic [7:0]      o_latency,
  output logic [7:0]      o_io_drive,
  output logic [7:0]      o_test_mode,
  output logic [7:0]      o_io_calib,
  output logic [7:0]      o_sr_bank_mask,
  output logic [7:0]      o_sr_segment_mask,
  output logic            o_auto_init_pending
);

  // ==========================================================
  // Decode
  logic       is_wo;
  logic       is_ro;
  logic [7:0] ro_value;
  logic       temp_flag_ff;
  logic       auto_init_pending_ff;

  // Address classification; anything unlisted is reserved
  always_comb begin
    is_wo    = 1'b0;
    is_ro    = 1'b0;
    ro_value = UNDEF_READ_DATA;
    case (i_cmd.addr)
      ADDR_BURST_FEATURE, ADDR_LATENCY, ADDR_IO_DRIVE, ADDR_TEST_MODE,
      ADDR_IO_CALIB, ADDR_SR_BANK_MASK, ADDR_SR_SEGMENT_MASK,
      ADDR_SOFT_RESET: begin
        is_wo = 1'b1;
      end
      ADDR_DEVICE_INFO: begin
        is_ro    = 1'b1;
        ro_value = {7'h00, auto_init_pending_ff} & MASK_DEVICE_INFO;
      end
      ADDR_REFRESH_STATUS: begin
        is_ro    = 1'b1;
        ro_value = {temp_flag_ff, 4'h0, REFRESH_RATE_NOMINAL} & MASK_REFRESH_STATUS;
      end
      ADDR_MAKER_ID: begin
        is_ro    = 1'b1;
        ro_value = ID_MAKER;
      end
      ADDR_REVISION_ONE: begin
        is_ro    = 1'b1;
        ro_value = ID_REVISION_ONE;
      end
      ADDR_REVISION_TWO: begin
        is_ro    = 1'b1;
        ro_value = ID_REVISION_TWO;
      end
      ADDR_GEOMETRY: begin
        is_ro    = 1'b1;
        ro_value = GEOMETRY_VALUE;
      end
      ADDR_DQ_PATTERN_A: begin
        is_ro    = 1'b1;
        ro_value = DQ_PATTERN_A_VALUE;
      end
      ADDR_DQ_PATTERN_B: begin
        is_ro    = 1'b1;
        ro_value = DQ_PATTERN_B_VALUE;
      end
      default: begin
        is_ro    = 1'b0;
        ro_value = UNDEF_READ_DATA;
      end
    endcase
  end

  logic wr_ok;
  assign wr_ok = i_cmd.wr && is_wo;

  // ==========================================================
  // Writable configuration registers; read-only targets drop the write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_burst_feature   <= RST_BURST_FEATURE;
      o_latency         <= RST_ZERO;
      o_io_drive        <= RST_ZERO;
      o_test_mode       <= RST_ZERO;
      o_io_calib        <= RST_ZERO;
      o_sr_bank_mask    <= RST_ZERO;
      o_sr_segment_mask <= RST_ZERO;
    end else if (wr_ok) begin
      case (i_cmd.addr)
        ADDR_BURST_FEATURE:   o_burst_feature   <= i_cmd.data;
        ADDR_LATENCY:         o_latency         <= i_cmd.data & MASK_LATENCY;
        ADDR_IO_DRIVE:        o_io_drive        <= i_cmd.data & MASK_IO_DRIVE;
        ADDR_TEST_MODE:       o_test_mode       <= i_cmd.data;
        ADDR_IO_CALIB:        o_io_calib        <= i_cmd.data;
        ADDR_SR_BANK_MASK:    o_sr_bank_mask    <= i_cmd.data;
        ADDR_SR_SEGMENT_MASK: o_sr_segment_mask <= i_cmd.data;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Auto-init status: set by soft reset, cleared by a bounded countdown
  logic [$clog2(AUTO_INIT_MAX_CYC+1)-1:0] init_cnt_ff;
  logic soft_reset;
  assign soft_reset = wr_ok && (i_cmd.addr == ADDR_SOFT_RESET);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      auto_init_pending_ff <= 1'b0;
      init_cnt_ff          <= '0;
    end else if (soft_reset) begin
      auto_init_pending_ff <= 1'b1;
      init_cnt_ff          <= ($bits(init_cnt_ff))'(AUTO_INIT_CYC - 1);
    end else if (auto_init_pending_ff) begin
      if (init_cnt_ff == '0) begin
        auto_init_pending_ff <= 1'b0;
      end else begin
        init_cnt_ff <= init_cnt_ff - 1'b1;
      end
    end
  end
  assign o_auto_init_pending = auto_init_pending_ff;

  // Age of the pending flag, kept only for the bound check; a fresh reset command restarts it
  logic [$bits(init_cnt_ff):0] pend_age_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || soft_reset) begin
      pend_age_ff <= '0;
    end else if (auto_init_pending_ff) begin
      pend_age_ff <= pend_age_ff + 1'b1;
    end else begin
      pend_age_ff <= '0;
    end
  end

  // Temperature flag is set by a sensor update pulse and then held; a soft reset clears it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      temp_flag_ff <= 1'b0;
    end else if (i_temp_update) begin
      temp_flag_ff <= 1'b1; // Set wins over clear
    end else if (soft_reset) begin
      temp_flag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Read burst: runs for every read issued in ST_IDLE, even for undefined reads; a read during a burst is dropped
  smrf_state_e state_ff;
  logic [1:0]  beat_ff;
  logic [7:0]  rd_data_ff;
  logic        strobe_ff;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_ff   <= ST_IDLE;
      beat_ff    <= '0;
      rd_data_ff <= '0;
      strobe_ff  <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          strobe_ff <= 1'b0;
          if (i_cmd.rd) begin
            state_ff   <= ST_BURST;
            beat_ff    <= 2'((BURST_BEATS - 1));
            rd_data_ff <= is_ro ? ro_value : UNDEF_READ_DATA;
            strobe_ff  <= 1'b1;
          end
        end
        ST_BURST: begin
          strobe_ff <= ~strobe_ff;
          if (beat_ff == '0) begin
            state_ff  <= ST_IDLE;
            strobe_ff <= 1'b0;
          end else begin
            beat_ff <= beat_ff - 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign o_rsp.valid  = (state_ff == ST_BURST);
  assign o_rsp.strobe = strobe_ff;
  assign o_rsp.data   = rd_data_ff;

  // ==========================================================
  // Checks
  property p_ro_write_ignored;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cmd.wr && !is_wo) |=> $stable(o_burst_feature) && $stable(o_latency);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("ro write changed state");

  sequence s_rd_start;
    (state_ff == ST_IDLE) && i_cmd.rd;
  endsequence
  property p_burst_runs;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_rd_start |=> o_rsp.valid [*4] ##1 !o_rsp.valid;
  endproperty
  a_burst_runs: assert property (p_burst_runs) else $error("read burst length wrong");

  property p_strobe_toggles;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_rsp.valid && $past(o_rsp.valid)) |-> o_rsp.strobe != $past(o_rsp.strobe);
  endproperty
  a_strobe_toggles: assert property (p_strobe_toggles) else $error("strobe not toggling");

  property p_reserved_bits_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s_rd_start ##0 (i_cmd.addr == ADDR_DEVICE_INFO)) |=> o_rsp.data[7:5] == 3'h0;
  endproperty
  a_reserved_bits_zero: assert property (p_reserved_bits_zero) else $error("reserved bits set");

  property p_write_lands;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cmd.wr && i_cmd.addr == ADDR_SR_BANK_MASK) |=> o_sr_bank_mask == $past(i_cmd.data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_init_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      soft_reset |=> o_auto_init_pending;
  endproperty
  a_init_set: assert property (p_init_set) else $error("pending not set");

  property p_init_bounded;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (pend_age_ff <= ($bits(pend_age_ff))'(AUTO_INIT_CYC));
  endproperty
  a_init_bounded: assert property (p_init_bounded) else $error("init count overrange");

  property p_reserved_no_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cmd.wr && !is_wo && !is_ro) |=> $stable(o_io_calib) && $stable(o_test_mode);
  endproperty
  a_reserved_no_write: assert property (p_reserved_no_write) else $error("reserved write hit");

  property p_class;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (s_rd_start ##0 is_wo) |=> o_rsp.data == UNDEF_READ_DATA;
  endproperty
  a_class: assert property (p_class) else $error("write-only read returned data");

endmodule
`default_nettype wire

// ### testbench/smrf_ctrl_model.sv
// Controller model issuing config read and write commands
`default_nettype none
module smrf_ctrl_model
  import smrf_pkg::*;
(
  input  wire logic      i_sys_clk,
  input  wire smrf_rsp_s i_rsp,
  output var smrf_cmd_s  o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_cmd = '0;

  // ==========================================================
  // Write one byte; idle address and data are inverted so stale values never look valid
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge i_sys_clk);
    o_cmd <= '{rd: 1'b0, wr: 1'b1, addr: a, data: d & m};
    @(posedge i_sys_clk);
    o_cmd <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~(d & m)};
  endtask

  // ==========================================================
  // Read one byte and judge the burst framing: valid, strobe phase, stable data
  task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_sys_clk);
    o_cmd <= '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    @(posedge i_sys_clk);
    o_cmd <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: 8'hff};
    ok = 1'b1;
    for (int k = 0; k < BURST_BEATS; k++) begin
      @(posedge i_sys_clk);
      if (k == 0) d = i_rsp.data;
      ok &= (i_rsp.valid === 1'b1) && (i_rsp.strobe === ~k[0]) && (i_rsp.data === d);
    end
    @(posedge i_sys_clk);
    ok &= (i_rsp.valid === 1'b0);
  endtask

  // ==========================================================
  // Idle commands only after a soft reset
  task automatic nop_wait();
    repeat (POST_RESET_IDLE_CYC) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/test_sdram_mode_register_file.sv
// Self-checking testbench of the mode-register file
`default_nettype none
module test_sdram_mode_register_file
  import smrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AUTO_CYC = 8;
  localparam logic [7:0] WA [7] = '{ADDR_BURST_FEATURE, ADDR_LATENCY, ADDR_IO_DRIVE,
    ADDR_TEST_MODE, ADDR_IO_CALIB, ADDR_SR_BANK_MASK, ADDR_SR_SEGMENT_MASK};
  localparam logic [7:0] WM [7] = '{MASK_FULL, MASK_LATENCY, MASK_IO_DRIVE,
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};
  localparam logic [7:0] RA [8] = '{ADDR_DEVICE_INFO, ADDR_REFRESH_STATUS, ADDR_MAKER_ID,
    ADDR_REVISION_ONE, ADDR_REVISION_TWO, ADDR_GEOMETRY, ADDR_DQ_PATTERN_A, ADDR_DQ_PATTERN_B};
  localparam logic [7:0] RE [8] = '{8'h00, {5'h00, REFRESH_RATE_NOMINAL}, ID_MAKER,
    ID_REVISION_ONE, ID_REVISION_TWO, GEOMETRY_VALUE, DQ_PATTERN_A_VALUE, DQ_PATTERN_B_VALUE};
  // Reserved, vendor, do-not-use and write-only addresses
  localparam logic [7:0] UA [6] = '{8'h01, 8'h0b, 8'h21, 8'h7f, 8'h80, 8'hff};

  logic            clk;
  logic            rst_n;
  logic            temp_upd;
  smrf_cmd_s       cmd;
  smrf_rsp_s       rsp;
  logic [7:0]      cfg [7];
  logic            pend;
  int              error_cnt;
  int              cmp_count;

  smrf_top #(.AUTO_INIT_CYC(AUTO_CYC)) i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_temp_update(temp_upd), .o_rsp(rsp),
    .o_burst_feature(cfg[0]), .o_latency(cfg[1]), .o_io_drive(cfg[2]), .o_test_mode(cfg[3]),
    .o_io_calib(cfg[4]), .o_sr_bank_mask(cfg[5]), .o_sr_segment_mask(cfg[6]),
    .o_auto_init_pending(pend));

  smrf_ctrl_model i_ctrl (.i_sys_clk(clk), .i_rsp(rsp), .o_cmd(cmd));

  // ==========================================================
  // Shared compare, read and closing tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_ctrl.cfg_rd(a, d, ok);
    chk(d, exp);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_state();
    @(negedge clk);
    chk(cfg[0], RST_BURST_FEATURE);
    chk({7'h00, pend}, 8'h00);
    rd_chk(ADDR_DEVICE_INFO, 8'h00);
  endtask

  // Writes of every writable register, one every second cycle with an idle cycle between
  task automatic t_writes();
    for (int k = 0; k < 7; k++) i_ctrl.cfg_wr(WA[k], 8'h3c + 8'(k * 17), WM[k]);
    @(negedge clk);
    for (int k = 0; k < 7; k++) chk(cfg[k], (8'h3c + 8'(k * 17)) & WM[k]);
  endtask

  // Writes to read-only places change nothing; every readable register reads back
  task automatic t_ro_write();
    for (int k = 0; k < 8; k++) i_ctrl.cfg_wr(RA[k], 8'hff, MASK_FULL);
    @(negedge clk);
    chk(cfg[0], 8'h3c);
    for (int k = 0; k < 8; k++) rd_chk(RA[k], RE[k]);
  endtask

  // Write-only and reserved reads still burst
  task automatic t_undef_reads();
    for (int k = 0; k < 6; k++) rd_chk(UA[k], UNDEF_READ_DATA);
  endtask

  // Temperature flag, then soft reset and auto-init countdown
  task automatic t_soft_reset();
    int n;
    @(posedge clk) temp_upd <= 1'b1;
    @(posedge clk) temp_upd <= 1'b0;
    rd_chk(ADDR_REFRESH_STATUS, {5'h10, REFRESH_RATE_NOMINAL});
    i_ctrl.cfg_wr(ADDR_SOFT_RESET, 8'h00, MASK_FULL);
    @(negedge clk);
    chk({7'h00, pend}, 8'h01);
    n = 0;
    while (pend === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n inside {[1:AUTO_CYC + 1]}}, 8'h01);
    i_ctrl.nop_wait();
    rd_chk(ADDR_DEVICE_INFO, 8'h00);
    rd_chk(ADDR_REFRESH_STATUS, {5'h00, REFRESH_RATE_NOMINAL});
  endtask

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    temp_upd = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_state();
    t_writes();
    t_ro_write();
    t_undef_reads();
    t_soft_reset();
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
